// file: hw/serial_tx_regs.vh
`ifndef SERIAL_TX_REGS_VH
`define SERIAL_TX_REGS_VH

// Segment layout, control byte
`define SEG_W 64
`define CTL_SCR_BIT 7
`define CTL_ACK_HI 6
`define CTL_ACK_LO 5
`define CTL_SEQ_HI 4
`define CTL_SEQ_LO 3
`define CTL_CNT_HI 2
`define CTL_CNT_LO 0
// Clear-request byte (byte 1, full layout)
`define CLR_BYTE 1
`define CLR_RX_BIT 1
`define CLR_TX_BIT 0
// First data byte position per layout
`define DATA_FIRST_FULL 2
`define DATA_FIRST_RED 1
`define DATA_MAX_FULL 3'h6
`define DATA_MAX_RED 3'h7
`define STAGE_W 56
`define SEQ_RESET 2'h3

// Transmit buffer
`define BUF_DEPTH 64
`define BUF_AW 6
`define BUF_CW 7
`define BUF_FULL 7'h40

// Register map (byte addresses)
`define REG_CTRL 12'h000
`define REG_STATUS 12'h004
`define REG_IRQ_STATUS 12'h008
`define REG_IRQ_CLEAR 12'h00C
`define REG_IRQ_ENABLE 12'h010
`define CTRL_LAYOUT_BIT 0
`define CTRL_RESET 1'h1
// Status register fields
`define ST_FILL_LO 0
`define ST_FLAG_BIT 8
`define ST_SEQ_LO 9
`define ST_ACK_LO 11
`define ST_BUSY_BIT 13

// Interrupt events
`define IRQ_W 5
`define EV_SEQ_ERR 0
`define EV_OVERFLOW 1
`define EV_ACCEPT 2
`define EV_TX_CLR 3
`define EV_RX_CLR 4

`endif

// file: hw/tx_byte_ram.v
`timescale 1ns/1ps
module tx_byte_ram (
    // Clock
    input wire ref_clk,
    input wire clk_en,
    // Write port
    input wire wr_en,
    input wire [5:0] wr_addr,
    input wire [7:0] wr_data,
    // Read port, data registered
    input wire rd_en,
    input wire [5:0] rd_addr,
    output reg [7:0] rd_data_q
);
`include "serial_tx_regs.vh"

    reg [7:0] mem [0:`BUF_DEPTH-1];

    // No reset on storage; pointers decide what is valid
    always @(posedge ref_clk) begin
        if (clk_en) begin
            if (wr_en) begin
                mem[wr_addr] <= wr_data;
            end
            if (rd_en) begin
                rd_data_q <= mem[rd_addr];
            end
        end
    end

endmodule

// file: hw/irq_status_bank.v
`timescale 1ns/1ps
module irq_status_bank #(
    parameter WIDTH = 5
) (
    // Clock and reset
    input wire ref_clk,
    input wire rst,
    input wire clk_en,
    // Events and software access
    input wire [WIDTH-1:0] set_evt,
    input wire clr_wr,
    input wire [WIDTH-1:0] clr_data,
    input wire en_wr,
    input wire [WIDTH-1:0] en_data,
    // State
    output reg [WIDTH-1:0] status_q,
    output reg [WIDTH-1:0] enable_q,
    output reg irq_q
);

    genvar i;
    // Sticky bits; an event in the clear cycle still sets
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
            always @(posedge ref_clk) begin
                if (rst) begin
                    status_q[i] <= 1'b0;
                    enable_q[i] <= 1'b0;
                end else if (clk_en) begin
                    if (set_evt[i]) begin
                        status_q[i] <= 1'b1;
                    end else if (clr_wr && clr_data[i]) begin
                        status_q[i] <= 1'b0;
                    end
                    if (en_wr) begin
                        enable_q[i] <= en_data[i];
                    end
                end
            end
        end
    endgenerate

    // Level output, one cycle behind the status bits
    always @(posedge ref_clk) begin
        if (rst) begin
            irq_q <= 1'b0;
        end else if (clk_en) begin
            irq_q <= |(status_q & enable_q);
        end
    end

endmodule

// file: hw/serial_tx_segment_handshake.v
// Notes on behaviour
// [R1] Falling edge of status clear request clears the reported status flag.
// [R2] With status clear request low, count, sequence and ack changes are ignored.
// [R3] Status clear request high or rising blocks both buffer clear requests.
// [R4] Controller echoes the input segment sequence into the ack field.
// [R5] Controller advances the output sequence 0,1,2,3,0 per new segment.
// [R6] Out-of-order output sequence means lost segments; flag an error.
// [R7] Valid byte count 0..7 says how many data bytes are taken. The full layout clamps a count of 7 to 6 data bytes.
// [R8] Receive clear with status clear request low empties the receive buffer.
// [R9] Transmit clear with status clear request low empties the transmit buffer.
// [R10] User data is collected in a 64-byte transmit buffer.
// [R11] Segments are 8 bytes: control byte, optional clear byte, data bytes.
// [R12] Full layout: byte 0 control, byte 1 clear bits, bytes 2..7 data.
// [R13] A segment is new only when its sequence differs; accepted once.
// [R14] Valid bytes are appended in ascending order from first data byte.
`timescale 1ns/1ps
module serial_tx_segment_handshake (
    // Clock, reset, enable
    input wire ref_clk,
    input wire rst,
    input wire clk_en,
    // APB slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata_q,
    output reg pready_q,
    output reg pslverr_q,
    // Output segment from the gateway
    input wire seg_valid,
    input wire [63:0] seg_data,
    // Serial transmit byte stream
    output reg [7:0] tx_byte_q,
    output reg tx_valid_q,
    input wire tx_ready,
    // Towards the receive side and input image
    output reg rx_buffer_clear_q,
    output reg status_flag_q,
    output reg [1:0] input_segment_ack_count_q,
    // Interrupt
    output wire irq
);
`include "serial_tx_regs.vh"

    localparam [1:0] ST_IDLE = 2'b01;
    localparam [1:0] ST_APPEND = 2'b10;

    // Byte n of a segment image
    function [7:0] seg_byte;
        input [63:0] seg;
        input [2:0] idx;
        begin
            seg_byte = seg[idx*8 +: 8];
        end
    endfunction

    // Cyclic successor of a sequence value
    function [1:0] seq_next;
        input [1:0] s;
        begin
            seq_next = s + 2'h1;
        end
    endfunction

    // Register bus signals
    wire apb_setup = psel && penable && !pready_q;
    wire apb_done = psel && penable && pready_q;
    wire apb_wr = apb_done && pwrite;
    reg full_control_layout_select_q;

    // Control byte and clear byte fields
    wire [7:0] ctl = seg_byte(seg_data, 3'h0);
    wire [7:0] clr = seg_byte(seg_data, 3'd`CLR_BYTE);
    wire status_clear_request = ctl[`CTL_SCR_BIT];
    wire [1:0] ack_field = ctl[`CTL_ACK_HI:`CTL_ACK_LO];
    wire [1:0] output_segment_seq = ctl[`CTL_SEQ_HI:`CTL_SEQ_LO];
    wire [2:0] valid_byte_count = ctl[`CTL_CNT_HI:`CTL_CNT_LO];
    wire receive_buffer_clear = clr[`CLR_RX_BIT];
    wire transmit_buffer_clear = clr[`CLR_TX_BIT];

    reg scr_prev_q;
    reg [1:0] state_q;
    reg [1:0] last_seq_q;
    reg [55:0] stage_q;
    reg [2:0] remain_q;
    reg [6:0] wr_ptr_q;
    reg [6:0] rd_ptr_q;
    reg fetch_q;

    wire [6:0] fill = wr_ptr_q - rd_ptr_q;
    wire buf_full = (fill == `BUF_FULL);
    wire buf_empty = (fill == 7'h00);

    // Edges of the status clear request, seen on sampled images
    wire scr_fall = seg_valid && scr_prev_q && !status_clear_request; // [R1]
    // Clear bits only exist in the full layout; a high or rising request blocks them
    wire clr_allowed = seg_valid && full_control_layout_select_q
                       && !status_clear_request; // [R3]
    wire tx_clear = clr_allowed && transmit_buffer_clear; // [R9]
    wire rx_clear = clr_allowed && receive_buffer_clear; // [R8]

    // New segment: only while request high, idle, and sequence changed
    wire seg_new = seg_valid && status_clear_request && (state_q == ST_IDLE)
                   && (output_segment_seq != last_seq_q); // [R2] [R13]
    wire seq_err = seg_new && (output_segment_seq != seq_next(last_seq_q)); // [R6]

    // Clamp the count to the data bytes the layout really carries
    wire [2:0] data_max = full_control_layout_select_q ? `DATA_MAX_FULL : `DATA_MAX_RED;
    wire [2:0] take_cnt = (valid_byte_count > data_max) ? data_max
                          : valid_byte_count; // [R7] [R11]
    wire [55:0] data_bytes = full_control_layout_select_q
                             ? {8'h00, seg_data[63:`DATA_FIRST_FULL*8]}
                             : seg_data[63:`DATA_FIRST_RED*8]; // [R12]

    // Append path
    wire appending = (state_q == ST_APPEND) && !tx_clear;
    wire buf_wr = appending && !buf_full;
    wire overflow = appending && buf_full;

    // Drain path: fetch one byte when the output stage is free
    wire rd_issue = !tx_clear && !tx_valid_q && !fetch_q && !buf_empty;

    // Status clear request history
    always @(posedge ref_clk) begin
        if (rst) begin
            scr_prev_q <= 1'b0;
        end else if (clk_en && seg_valid) begin
            scr_prev_q <= status_clear_request;
        end
    end

    // Segment acceptance and byte append sequencer
    always @(posedge ref_clk) begin
        if (rst) begin
            state_q <= ST_IDLE;
            last_seq_q <= `SEQ_RESET;
            stage_q <= 56'h00000000000000;
            remain_q <= 3'h0;
            input_segment_ack_count_q <= 2'h0;
        end else if (clk_en) begin
            case (state_q)
                ST_IDLE: begin
                    if (seg_new) begin
                        last_seq_q <= output_segment_seq; // [R13]
                        input_segment_ack_count_q <= ack_field;
                        stage_q <= data_bytes;
                        remain_q <= take_cnt; // [R7]
                        if (take_cnt != 3'h0) begin
                            state_q <= ST_APPEND;
                        end
                    end
                end
                ST_APPEND: begin
                    // Flushing aborts the bytes still waiting
                    if (tx_clear || remain_q == 3'h1) begin
                        state_q <= ST_IDLE;
                    end
                    stage_q <= {8'h00, stage_q[55:8]}; // [R14]
                    remain_q <= remain_q - 3'h1;
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // Buffer pointers; one extra pointer bit tells full from empty
    always @(posedge ref_clk) begin
        if (rst) begin
            wr_ptr_q <= 7'h00;
            rd_ptr_q <= 7'h00;
        end else if (clk_en) begin
            if (tx_clear) begin
                wr_ptr_q <= 7'h00; // [R9]
                rd_ptr_q <= 7'h00;
            end else begin
                if (buf_wr) begin
                    wr_ptr_q <= wr_ptr_q + 7'h01; // [R10]
                end
                if (rd_issue) begin
                    rd_ptr_q <= rd_ptr_q + 7'h01;
                end
            end
        end
    end

    wire [7:0] ram_rd_data;

    tx_byte_ram u_ram (
        .ref_clk(ref_clk),
        .clk_en(clk_en),
        .wr_en(buf_wr),
        .wr_addr(wr_ptr_q[5:0]),
        .wr_data(stage_q[7:0]),
        .rd_en(rd_issue),
        .rd_addr(rd_ptr_q[5:0]),
        .rd_data_q(ram_rd_data)
    );

    // Output stage; RAM latency is one cycle so a fetch flag bridges it
    always @(posedge ref_clk) begin
        if (rst) begin
            fetch_q <= 1'b0;
            tx_valid_q <= 1'b0;
            tx_byte_q <= 8'h00;
        end else if (clk_en) begin
            if (tx_clear) begin
                fetch_q <= 1'b0;
                tx_valid_q <= 1'b0; // [R9]
            end else begin
                fetch_q <= rd_issue;
                if (fetch_q) begin
                    tx_byte_q <= ram_rd_data;
                    tx_valid_q <= 1'b1;
                end else if (tx_valid_q && tx_ready) begin
                    tx_valid_q <= 1'b0;
                end
            end
        end
    end

    // Reported status flag: errors set it, falling request edge clears it
    always @(posedge ref_clk) begin
        if (rst) begin
            status_flag_q <= 1'b0;
            rx_buffer_clear_q <= 1'b0;
        end else if (clk_en) begin
            if (seq_err || overflow) begin
                status_flag_q <= 1'b1;
            end else if (scr_fall) begin
                status_flag_q <= 1'b0; // [R1]
            end
            rx_buffer_clear_q <= rx_clear; // [R8]
        end
    end

    // Interrupt events
    wire [4:0] events;
    assign events[`EV_SEQ_ERR] = seq_err;
    assign events[`EV_OVERFLOW] = overflow;
    assign events[`EV_ACCEPT] = seg_new;
    assign events[`EV_TX_CLR] = tx_clear;
    assign events[`EV_RX_CLR] = rx_clear;

    wire [4:0] irq_status;
    wire [4:0] irq_enable;
    wire wr_clear = apb_wr && (paddr == `REG_IRQ_CLEAR);
    wire wr_enable = apb_wr && (paddr == `REG_IRQ_ENABLE);

    irq_status_bank #(
        .WIDTH(`IRQ_W)
    ) u_irq (
        .ref_clk(ref_clk),
        .rst(rst),
        .clk_en(clk_en),
        .set_evt(events),
        .clr_wr(wr_clear),
        .clr_data(pwdata[4:0]),
        .en_wr(wr_enable),
        .en_data(pwdata[4:0]),
        .status_q(irq_status),
        .enable_q(irq_enable),
        .irq_q(irq)
    );

    // Read mux; unmapped addresses read zero and flag an error
    reg [31:0] rd_mux;
    reg addr_ok;
    always @* begin
        rd_mux = 32'h00000000;
        addr_ok = 1'b1;
        case (paddr)
            `REG_CTRL: begin
                rd_mux[`CTRL_LAYOUT_BIT] = full_control_layout_select_q;
            end
            `REG_STATUS: begin
                rd_mux[`ST_FILL_LO +: 7] = fill;
                rd_mux[`ST_FLAG_BIT] = status_flag_q;
                rd_mux[`ST_SEQ_LO +: 2] = last_seq_q;
                rd_mux[`ST_ACK_LO +: 2] = input_segment_ack_count_q;
                rd_mux[`ST_BUSY_BIT] = (state_q == ST_APPEND);
            end
            `REG_IRQ_STATUS: begin
                rd_mux[4:0] = irq_status;
            end
            `REG_IRQ_CLEAR: begin
                rd_mux = 32'h00000000;
            end
            `REG_IRQ_ENABLE: begin
                rd_mux[4:0] = irq_enable;
            end
            default: begin
                addr_ok = 1'b0;
            end
        endcase
    end

    // APB slave: one wait state, data and error captured on the same edge that raises ready
    always @(posedge ref_clk) begin
        if (rst) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h00000000;
            full_control_layout_select_q <= `CTRL_RESET;
        end else if (clk_en) begin
            pready_q <= apb_setup;
            if (apb_setup) begin
                pslverr_q <= !addr_ok;
                prdata_q <= pwrite ? 32'h00000000 : rd_mux;
            end else begin
                pslverr_q <= 1'b0;
            end
            if (apb_wr && paddr == `REG_CTRL) begin
                full_control_layout_select_q <= pwdata[`CTRL_LAYOUT_BIT]; // [R12]
            end
        end
    end

endmodule

// file: verif/seg_handshake_chk.sv
`timescale 1ns/1ps
module seg_handshake_chk (
    // Clock and reset
    input wire ref_clk,
    input wire rst,
    input wire clk_en,
    // APB answer side
    input wire psel,
    input wire penable,
    input wire pready_q,
    input wire pslverr_q,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    // Segment and outputs
    input wire seg_valid,
    input wire [63:0] seg_data,
    input wire [7:0] tx_byte_q,
    input wire tx_valid_q,
    input wire tx_ready,
    input wire rx_buffer_clear_q,
    input wire status_flag_q,
    input wire [1:0] input_segment_ack_count_q
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    // Layout select shadowed from bus writes; clear bits exist only in the full layout
    logic layout_q;
    always @(posedge ref_clk) begin
        if (rst) begin
            layout_q <= 1'b1;
        end else if (clk_en && psel && penable && pready_q && pwrite && paddr == 12'h000) begin
            layout_q <= pwdata[0];
        end
    end

    // Bus answer timing
    a_pready_one_cycle: assert property (pready_q && clk_en |=> !pready_q)
        else $error("pready held longer than one cycle");
    a_apb_one_wait: assert property (psel && penable && !pready_q && clk_en |=> pready_q)
        else $error("pready missing after one wait state");
    a_slverr_with_ready: assert property (pslverr_q |-> pready_q)
        else $error("pslverr outside the answer cycle");
    // Receive clear only from an allowed request, and always then
    a_rx_clear_cause: assert property (rx_buffer_clear_q |->
        $past(seg_valid && layout_q && !seg_data[7] && seg_data[9]))
        else $error("receive clear without an allowed request");
    a_rx_clear_done: assert property (seg_valid && layout_q && !seg_data[7] && seg_data[9]
        && clk_en
        |=> rx_buffer_clear_q)
        else $error("allowed receive clear request not honoured");
    // A stalled byte stays put unless a transmit clear aborts it
    a_tx_hold_byte: assert property (tx_valid_q && !tx_ready
        && !(seg_valid && layout_q && !seg_data[7] && seg_data[8])
        |=> tx_valid_q && $stable(tx_byte_q))
        else $error("stalled transmit byte changed");
    a_flag_clear_cause: assert property ($fell(status_flag_q) |->
        $past(seg_valid && !seg_data[7]))
        else $error("status flag cleared without falling request");
    a_ack_from_segment: assert property ($changed(input_segment_ack_count_q) |->
        $past(seg_valid && seg_data[7]) && input_segment_ack_count_q == $past(seg_data[6:5]))
        else $error("ack field changed without an accepted segment");

    cover property (rx_buffer_clear_q);
    cover property ($fell(status_flag_q));
    cover property (tx_valid_q && tx_ready);
    cover property (!layout_q && tx_valid_q && tx_ready);
endmodule

bind serial_tx_segment_handshake seg_handshake_chk chk (.ref_clk(ref_clk), .rst(rst),
    .clk_en(clk_en), .psel(psel), .penable(penable), .pready_q(pready_q),
    .pslverr_q(pslverr_q), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .seg_valid(seg_valid), .seg_data(seg_data),
    .tx_byte_q(tx_byte_q), .tx_valid_q(tx_valid_q), .tx_ready(tx_ready),
    .rx_buffer_clear_q(rx_buffer_clear_q), .status_flag_q(status_flag_q),
    .input_segment_ack_count_q(input_segment_ack_count_q));

// file: verif/gateway_model.sv
`timescale 1ns/1ps
module gateway_model (
    // Clock
    input wire ref_clk,
    // Segment image towards the device
    output logic seg_valid,
    output logic [63:0] seg_data
);
    // No image before the first segment
    initial begin
        seg_valid = 1'b0;
        seg_data = 64'h0;
    end

    // Image is held until the next one, as a gateway refreshes cyclically
    task put(input logic scr, input logic [1:0] ack, input logic [1:0] seq,
        input logic [2:0] cnt, input logic [1:0] clr, input logic [47:0] data);
        @(posedge ref_clk);
        seg_valid <= 1'b1;
        seg_data <= {data, 6'h00, clr, scr, ack, seq, cnt};
    endtask
endmodule

// file: verif/serial_tx_segment_handshake_tb.sv
`timescale 1ns/1ps
module serial_tx_segment_handshake_tb;
    logic ref_clk, rst, psel, penable, pwrite, tx_ready, stall, se, clk_en, red;
    logic [55:0] img;
    logic [10:0] snap;
    logic [11:0] paddr;
    logic [31:0] pwdata, rd, prdata_q;
    logic pready_q, pslverr_q, seg_valid, tx_valid_q, rx_buffer_clear_q, status_flag_q, irq;
    logic [63:0] seg_data;
    logic [7:0] tx_byte_q;
    logic [1:0] input_segment_ack_count_q, seq, ack;
    logic [47:0] dat;
    logic [7:0] exp_q[$];
    int err_total, checks, cyc, rx_pulses;

    serial_tx_segment_handshake dut (.ref_clk(ref_clk), .rst(rst), .clk_en(clk_en),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata_q(prdata_q), .pready_q(pready_q), .pslverr_q(pslverr_q),
        .seg_valid(seg_valid), .seg_data(seg_data), .tx_byte_q(tx_byte_q),
        .tx_valid_q(tx_valid_q), .tx_ready(tx_ready), .rx_buffer_clear_q(rx_buffer_clear_q),
        .status_flag_q(status_flag_q), .input_segment_ack_count_q(input_segment_ack_count_q),
        .irq(irq));
    gateway_model gw (.ref_clk(ref_clk), .seg_valid(seg_valid), .seg_data(seg_data));

    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    task check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task close_out;
        if (err_total == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // One APB transfer; waits for pready, bounded only by the cycle ceiling
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        @(posedge ref_clk);
        while (pready_q !== 1'b1) @(posedge ref_clk);
        rd = prdata_q;
        se = pslverr_q;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Random segment; bytes queued only when the device should take them
    task seg(input logic s, input logic [1:0] clr, input logic take, input logic [2:0] n);
        ack = 2'($urandom);
        dat[47:16] = $urandom;
        dat[15:0] = 16'($urandom);
        // Data bytes as the selected layout places them
        img = red ? {dat, 6'h00, clr} : {8'h00, dat};
        gw.put(s, ack, seq, n, clr, dat);
        if (take)
            for (int i = 0; i < ((!red && n == 3'h7) ? 6 : n); i++)
                exp_q.push_back(img[8*i+:8]);
        if (s)
            seq = seq + 2'h1;
        repeat (12) @(posedge ref_clk);
    endtask

    // Line side: random stalls, byte order check, cycle ceiling
    always @(posedge ref_clk) begin
        cyc++;
        tx_ready <= !stall && ($urandom_range(3, 0) != 0);
        if (rx_buffer_clear_q === 1'b1)
            rx_pulses++;
        if (clk_en && tx_valid_q === 1'b1 && tx_ready === 1'b1) begin
            if (exp_q.size() == 0)
                check(32'h100, 32'h0);
            else
                check(tx_byte_q, exp_q.pop_front());
        end
        if (cyc == 5000) begin
            err_total++;
            close_out();
        end
    end

    initial begin
        rst = 1'b1;
        {psel, penable, pwrite, stall, tx_ready} = 5'h00;
        clk_en = 1'b1;
        red = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        seq = 2'h0;
        void'($urandom(40));
        repeat (4) @(posedge ref_clk);
        rst <= 1'b0;
        // Reset values and an unmapped place
        apb(0, 12'h004, 0); check(rd, 32'h0000_0600);
        apb(0, 12'h000, 0); check(rd, 32'h1);
        apb(0, 12'h020, 0); check(rd, 32'h0);
        check(se, 1);
        apb(1, 12'h010, 32'h1F);
        apb(0, 12'h010, 0); check(rd, 32'h1F);
        // In-order traffic with random counts
        for (int k = 0; k < 12; k++) begin
            seg(1, 2'h0, 1, 3'($urandom_range(6, 0)));
            check(input_segment_ack_count_q, ack);
        end
        // Frozen enable: no output moves and no byte is handed over
        clk_en <= 1'b0;
        @(posedge ref_clk);
        snap = {tx_valid_q, tx_byte_q, input_segment_ack_count_q};
        repeat (6) @(posedge ref_clk);
        check({tx_valid_q, tx_byte_q, input_segment_ack_count_q}, snap);
        clk_en <= 1'b1;
        // Reduced layout: seven bytes from byte 1, which holds no clear bits there
        apb(1, 12'h000, 32'h0);
        red = 1'b1;
        seg(1, 2'h3, 1, 3'h7); check(rx_pulses, 0);
        apb(1, 12'h000, 32'h1);
        red = 1'b0;
        // Full layout carries six data bytes, so a count of seven is clamped
        seg(1, 2'h0, 1, 3'h7); check(input_segment_ack_count_q, ack);
        // Request low: new count and sequence ignored
        seg(0, 2'h0, 0, 3'h5);
        apb(0, 12'h004, 0); check(rd[10:9], 2'(seq - 2'h1));
        // Skipped sequence still taken but reported as lost
        apb(1, 12'h00C, 32'h1F);
        repeat (3) @(posedge ref_clk);
        check(irq, 0);
        seq = seq + 2'h1;
        seg(1, 2'h0, 1, 3'h6);
        check(status_flag_q, 1);
        check(irq, 1);
        apb(0, 12'h008, 0); check(rd[0], 1);
        // Falling request clears the flag
        seg(0, 2'h0, 0, 3'h0); check(status_flag_q, 0);
        // Clears ignored on rising and high request, honoured when low
        stall = 1'b1;
        seg(1, 2'h3, 1, 3'h6); check(rx_pulses, 0);
        seg(0, 2'h3, 0, 3'h4);
        exp_q.delete();
        check(rx_pulses != 0, 1);
        apb(0, 12'h004, 0); check(rd[6:0], 0);
        // Stalled line: 66 bytes against a 64-byte buffer
        for (int k = 0; k < 11; k++) seg(1, 2'h0, 0, 3'h6);
        apb(0, 12'h008, 0); check(rd[1], 1);
        seg(0, 2'h1, 0, 3'h0);
        apb(0, 12'h004, 0); check(rd[6:0], 0);
        stall = 1'b0;
        seg(1, 2'h0, 1, 3'h6);
        while (exp_q.size() != 0) @(posedge ref_clk);
        repeat (20) @(posedge ref_clk);
        close_out();
    end
endmodule
